// *** design/aoc_pkg.sv ***
// Constants, register map and state types for the automatic block control.
// Assumes one clock (MCLK, 20 MHz) and a synchronous active-high reset.
package aoc_pkg;
  // Register port widths
  localparam int AW = 4;
  localparam int DW = 8;
  // Register byte offsets
  localparam logic [AW-1:0] CTRL_OFS = 4'h0;
  localparam logic [AW-1:0] STAT_OFS = 4'h4;
  // Control register layout and reset value
  localparam int            RAPID_DRY_BIT = 0;
  localparam logic [DW-1:0] CTRL_RST      = 8'h00;
  // Status register layout
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_HALT_BIT  = 4;
  localparam int STAT_STRB_BIT  = 5;
  localparam int STAT_RST_BIT   = 6;
  localparam int STAT_RWD_BIT   = 7;
  // Manual feedrate code width (weights 1 to 16)
  localparam int FCODE_W = 5;
  // Delay from rewind reset to in-reset status
  localparam int CLK_HZ        = 20000000;
  localparam int RST_DELAY_MS  = 500;
  localparam int RST_DELAY_CYC = RST_DELAY_MS * (CLK_HZ / 1000);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_START = 3'h1,
    ST_RUN   = 3'h3,
    ST_INPOS = 3'h2,
    ST_MSTW  = 3'h6,
    ST_HALT  = 3'h4,
    ST_DECEL = 3'h7,
    ST_RSTW  = 3'h5
  } aoc_state_type;

  typedef enum logic [1:0] {
    MOT_NONE = 2'h0,
    MOT_POS  = 2'h1,
    MOT_CUT  = 2'h2
  } aoc_motion_type;

  typedef enum logic [1:0] {
    FEED_PROG   = 2'h0,
    FEED_MAXCUT = 2'h1,
    FEED_MANUAL = 2'h2,
    FEED_RAPID  = 2'h3
  } aoc_feed_type;
endpackage

// *** design/aoc_block_ctrl.sv ***
// Automatic-operation block sequencer: stepping, start interlocks, dry run,
// in-position stop and the three reset inputs.
// Assumes all inputs synchronous to MCLK; block descriptors held stable
// by the execution core from BLOCK_START until the block ends.
`timescale 1ns/10ps
module aoc_block_ctrl #(
  parameter int RST_DLY_CYC = aoc_pkg::RST_DELAY_CYC
) (
  input  wire logic                       MCLK,
  input  wire logic                       SYS_RST,
  input  wire logic [aoc_pkg::AW-1:0]     REG_ADDR,
  input  wire logic [aoc_pkg::DW-1:0]     REG_WDATA,
  input  wire logic                       REG_WR,
  input  wire logic                       REG_RD,
  output logic      [aoc_pkg::DW-1:0]     REG_RDATA,
  input  wire logic                       SINGLE_STEP_REQUEST,
  input  wire logic                       CYCLE_START_REQUEST,
  input  wire logic                       BLOCK_START_PERMIT_N,
  input  wire logic                       CUTTING_START_PERMIT_N,
  input  wire logic                       DRY_RUN_SELECT,
  input  wire logic                       RAPID_TRAVERSE_SELECT,
  input  wire logic                       MANUAL_OVERRIDE_VALID,
  input  wire logic [aoc_pkg::FCODE_W-1:0] MANUAL_FEEDRATE_CODE,
  input  wire logic                       INPOSITION_CHECK_REQUEST,
  input  wire logic                       SOFT_RESET_REQUEST,
  input  wire logic                       MODAL_INIT_RESET_REQUEST,
  input  wire logic                       RESET_AND_REWIND_REQUEST,
  input  wire logic                       FUNCTION_FINISH_FALLING,
  input  wire logic                       FUNCTION_FINISH_RISING,
  input  wire logic                       MEMORY_MODE,
  input  wire logic                       MANUAL_MODE,
  input  wire logic                       BLK_VALID,
  input  wire logic [1:0]                 BLK_MOTION,
  input  wire logic                       BLK_STOP_OK,
  input  wire logic                       BLK_EXACT_STOP,
  input  wire logic                       BLK_MST,
  input  wire logic                       MOTION_DONE,
  input  wire logic                       IN_POSITION,
  input  wire logic                       AXES_STOPPED,
  output logic                            BLOCK_START,
  output logic                            AUTO_ACTIVE,
  output logic                            SINGLE_STOPPED,
  output logic                            FUNC_STROBE,
  output logic      [1:0]                 FEED_SOURCE,
  output logic      [aoc_pkg::FCODE_W-1:0] FEED_CODE,
  output logic                            CUT_OVR_EN,
  output logic                            RAPID_OVR_EN,
  output logic                            AXIS_DECEL,
  output logic                            AXIS_STOP,
  output logic                            IN_RESET,
  output logic                            IN_REWIND,
  output logic                            MODAL_INIT,
  output logic                            OFFSET_CANCEL,
  output logic                            MEM_INDEX,
  output logic                            ALARM_CLEAR,
  output logic                            MCODE_OUT_CLEAR,
  output logic                            MANUAL_INHIBIT
);
  localparam int CW = $clog2(RST_DLY_CYC + 1);

  aoc_pkg::aoc_state_type     state_r;
  aoc_pkg::aoc_state_type     state_nxt;
  logic [aoc_pkg::DW-1:0]     ctrl_r;
  logic [CW-1:0]              dly_cnt_r;
  logic                       sstep_r;
  logic                       cst_r;
  logic                       cst_prv_r;
  logic                       bperm_n_r;
  logic                       cperm_n_r;
  logic                       dry_r;
  logic                       rt_r;
  logic                       manual_override_valid_r;
  logic                       erd_r;
  logic                       soft_r;
  logic                       soft_prv_r;
  logic                       modal_r;
  logic                       modal_prv_r;
  logic                       rrw_r;
  logic                       rrw_prv_r;
  logic                       finf_r;
  logic                       finr_r;
  logic [aoc_pkg::FCODE_W-1:0] fcode_r;
  logic                       strobe_r;
  logic                       strobe_nxt;
  logic                       fin_seen_r;
  logic                       fin_seen_nxt;
  logic                       start_nxt;
  logic                       rwd_r;
  logic                       rrw_rst_r;
  logic                       cst_fall;
  logic                       soft_rise;
  logic                       modal_rise;
  logic                       rrw_rise;
  logic                       rrw_evt;
  logic                       is_cut;
  logic                       perm_ok;
  logic                       need_inpos;
  logic                       fin_any;

  // Halt at block end only where the cycle allows it
  function automatic aoc_pkg::aoc_state_type blk_end(input logic sstep,
                                                     input logic stop_ok);
    blk_end = (sstep && stop_ok) ? aoc_pkg::ST_HALT : aoc_pkg::ST_START;
  endfunction

  // Input sampling; permits reset to 0 so they grant until the first sample after reset
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      sstep_r     <= 1'b0;
      cst_r       <= 1'b0;
      cst_prv_r   <= 1'b0;
      bperm_n_r   <= 1'b0;
      cperm_n_r   <= 1'b0;
      dry_r       <= 1'b0;
      rt_r        <= 1'b0;
      manual_override_valid_r      <= 1'b0;
      erd_r       <= 1'b0;
      soft_r      <= 1'b0;
      soft_prv_r  <= 1'b0;
      modal_r     <= 1'b0;
      modal_prv_r <= 1'b0;
      rrw_r       <= 1'b0;
      rrw_prv_r   <= 1'b0;
      finf_r      <= 1'b0;
      finr_r      <= 1'b0;
      fcode_r     <= '0;
    end else begin
      sstep_r     <= SINGLE_STEP_REQUEST;
      cst_r       <= CYCLE_START_REQUEST;
      cst_prv_r   <= cst_r;
      bperm_n_r   <= BLOCK_START_PERMIT_N;
      cperm_n_r   <= CUTTING_START_PERMIT_N;
      dry_r       <= DRY_RUN_SELECT;
      rt_r        <= RAPID_TRAVERSE_SELECT;
      manual_override_valid_r      <= MANUAL_OVERRIDE_VALID;
      erd_r       <= INPOSITION_CHECK_REQUEST;
      soft_r      <= SOFT_RESET_REQUEST;
      soft_prv_r  <= soft_r;
      modal_r     <= MODAL_INIT_RESET_REQUEST;
      modal_prv_r <= modal_r;
      rrw_r       <= RESET_AND_REWIND_REQUEST;
      rrw_prv_r   <= rrw_r;
      finf_r      <= FUNCTION_FINISH_FALLING;
      finr_r      <= FUNCTION_FINISH_RISING;
      fcode_r     <= MANUAL_FEEDRATE_CODE;
    end
  end

  assign cst_fall   = cst_prv_r & ~cst_r;
  assign soft_rise  = soft_r & ~soft_prv_r;
  assign modal_rise = modal_r & ~modal_prv_r;
  assign rrw_rise   = rrw_r & ~rrw_prv_r;
  assign rrw_evt    = (state_r == aoc_pkg::ST_DECEL) & AXES_STOPPED;
  assign is_cut     = (BLK_MOTION == aoc_pkg::MOT_CUT);
  // Same check for core-made cycle blocks; no pause state entered
  assign perm_ok    = ~bperm_n_r & ~(is_cut & cperm_n_r);
  assign need_inpos = is_cut & (erd_r | BLK_EXACT_STOP);
  assign fin_any    = finf_r | finr_r;

  always_comb begin
    state_nxt    = state_r;
    strobe_nxt   = strobe_r;
    fin_seen_nxt = fin_seen_r;
    start_nxt    = 1'b0;
    case (state_r)
      aoc_pkg::ST_IDLE, aoc_pkg::ST_HALT: begin
        if (cst_fall && !rrw_r) begin
          state_nxt = aoc_pkg::ST_START;
        end
      end
      aoc_pkg::ST_START: begin
        if (!BLK_VALID) begin
          state_nxt = aoc_pkg::ST_IDLE;
        end else if (perm_ok) begin
          start_nxt = 1'b1;
          state_nxt = aoc_pkg::ST_RUN;
        end
      end
      aoc_pkg::ST_RUN: begin
        if (MOTION_DONE) begin
          if (need_inpos) begin
            state_nxt = aoc_pkg::ST_INPOS;
          end else if (BLK_MST) begin
            state_nxt  = aoc_pkg::ST_MSTW;
            strobe_nxt = 1'b1;
          end else begin
            state_nxt = blk_end(sstep_r, BLK_STOP_OK);
          end
        end
      end
      aoc_pkg::ST_INPOS: begin
        if (IN_POSITION) begin
          if (BLK_MST) begin
            state_nxt  = aoc_pkg::ST_MSTW;
            strobe_nxt = 1'b1;
          end else begin
            state_nxt = blk_end(sstep_r, BLK_STOP_OK);
          end
        end
      end
      aoc_pkg::ST_MSTW: begin
        if (fin_any) begin
          strobe_nxt   = 1'b0;
          fin_seen_nxt = 1'b1;
        end else if (fin_seen_r) begin
          fin_seen_nxt = 1'b0;
          state_nxt    = blk_end(sstep_r, BLK_STOP_OK);
        end
      end
      aoc_pkg::ST_DECEL: begin
        if (AXES_STOPPED) begin
          state_nxt = aoc_pkg::ST_RSTW;
        end
      end
      aoc_pkg::ST_RSTW: begin
        if (!rrw_r) begin
          state_nxt = aoc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = aoc_pkg::ST_IDLE;
      end
    endcase
    // Resets override the sequence (soft and modal not in ST_DECEL or ST_RSTW); rewind wins over the others
    if (rrw_rise) begin
      state_nxt    = aoc_pkg::ST_DECEL;
      strobe_nxt   = 1'b0;
      fin_seen_nxt = 1'b0;
      start_nxt    = 1'b0;
    end else if ((soft_rise || modal_rise) && state_r != aoc_pkg::ST_RSTW
                 && state_r != aoc_pkg::ST_DECEL) begin
      state_nxt    = aoc_pkg::ST_IDLE;
      fin_seen_nxt = 1'b0;
      start_nxt    = 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      state_r    <= aoc_pkg::ST_IDLE;
      strobe_r   <= 1'b0;
      fin_seen_r <= 1'b0;
      BLOCK_START <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      strobe_r   <= strobe_nxt;
      fin_seen_r <= fin_seen_nxt;
      BLOCK_START <= start_nxt;
    end
  end

  // Reset side effects as one-cycle pulses to the core
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      MODAL_INIT      <= 1'b0;
      OFFSET_CANCEL   <= 1'b0;
      MEM_INDEX       <= 1'b0;
      ALARM_CLEAR     <= 1'b0;
      MCODE_OUT_CLEAR <= 1'b0;
      AXIS_STOP       <= 1'b0;
    end else begin
      MODAL_INIT      <= modal_rise | rrw_evt;
      OFFSET_CANCEL   <= modal_rise | rrw_evt;
      MEM_INDEX       <= soft_rise | (rrw_evt & MEMORY_MODE);
      ALARM_CLEAR     <= soft_rise | modal_rise | rrw_evt;
      MCODE_OUT_CLEAR <= soft_rise | modal_rise | rrw_evt;
      AXIS_STOP       <= soft_rise | modal_rise;
    end
  end

  // Rewind status and delayed in-reset; counter saturates at the delay
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      rwd_r     <= 1'b0;
      rrw_rst_r <= 1'b0;
      dly_cnt_r <= '0;
    end else if (!rrw_r) begin
      rwd_r     <= 1'b0;
      rrw_rst_r <= 1'b0;
      dly_cnt_r <= '0;
    end else if (rrw_evt) begin
      rwd_r     <= 1'b1;
      dly_cnt_r <= '0;
    end else if (rwd_r && !rrw_rst_r) begin
      if (dly_cnt_r == CW'(RST_DLY_CYC - 1)) begin
        rrw_rst_r <= 1'b1;
      end
      dly_cnt_r <= dly_cnt_r + 1'b1;
    end
  end

  // Feed selection; dry run only outside manual operation
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      FEED_SOURCE  <= aoc_pkg::FEED_PROG;
      FEED_CODE    <= '0;
      CUT_OVR_EN   <= 1'b0;
      RAPID_OVR_EN <= 1'b0;
    end else begin
      FEED_CODE <= fcode_r;
      if (BLK_MOTION == aoc_pkg::MOT_POS) begin
        if (dry_r && !MANUAL_MODE && ctrl_r[aoc_pkg::RAPID_DRY_BIT]
            && !rt_r) begin
          FEED_SOURCE  <= aoc_pkg::FEED_MANUAL;
          CUT_OVR_EN   <= 1'b0;
          RAPID_OVR_EN <= 1'b0;
        end else begin
          FEED_SOURCE  <= aoc_pkg::FEED_RAPID;
          CUT_OVR_EN   <= 1'b0;
          RAPID_OVR_EN <= 1'b1;
        end
      end else if (dry_r && !MANUAL_MODE) begin
        if (rt_r) begin
          FEED_SOURCE  <= aoc_pkg::FEED_MAXCUT;
          CUT_OVR_EN   <= 1'b0;
          RAPID_OVR_EN <= 1'b0;
        end else begin
          FEED_SOURCE  <= aoc_pkg::FEED_MANUAL;
          CUT_OVR_EN   <= manual_override_valid_r;
          RAPID_OVR_EN <= 1'b0;
        end
      end else begin
        FEED_SOURCE  <= aoc_pkg::FEED_PROG;
        CUT_OVR_EN   <= 1'b1;
        RAPID_OVR_EN <= 1'b0;
      end
    end
  end

  // Register port: unmapped reads return zero, writes ignored
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      ctrl_r    <= aoc_pkg::CTRL_RST;
      REG_RDATA <= '0;
    end else begin
      if (REG_WR && REG_ADDR == aoc_pkg::CTRL_OFS) begin
        ctrl_r <= REG_WDATA;
      end
      REG_RDATA <= '0;
      if (REG_RD) begin
        case (REG_ADDR)
          aoc_pkg::CTRL_OFS: REG_RDATA <= ctrl_r;
          aoc_pkg::STAT_OFS: begin
            REG_RDATA[aoc_pkg::STAT_STATE_LSB +: 3] <= state_r;
            REG_RDATA[aoc_pkg::STAT_HALT_BIT]       <= SINGLE_STOPPED;
            REG_RDATA[aoc_pkg::STAT_STRB_BIT]       <= strobe_r;
            REG_RDATA[aoc_pkg::STAT_RST_BIT]        <= IN_RESET;
            REG_RDATA[aoc_pkg::STAT_RWD_BIT]        <= rwd_r;
          end
          default: REG_RDATA <= '0;
        endcase
      end
    end
  end

  assign FUNC_STROBE    = strobe_r;
  assign IN_REWIND      = rwd_r;
  assign IN_RESET       = soft_r | modal_r | rrw_rst_r;
  assign AXIS_DECEL     = (state_r == aoc_pkg::ST_DECEL);
  assign MANUAL_INHIBIT = rrw_r;
  assign SINGLE_STOPPED = (state_r == aoc_pkg::ST_HALT);
  assign AUTO_ACTIVE    = (state_r == aoc_pkg::ST_START) | (state_r == aoc_pkg::ST_RUN)
                        | (state_r == aoc_pkg::ST_INPOS) | (state_r == aoc_pkg::ST_MSTW);
endmodule

// *** bench/aoc_block_ctrl_assertions.sv ***
// Concurrent checks on the ports of the automatic block control.
// Assumes binding into aoc_block_ctrl with the same RST_DLY_CYC value.
`timescale 1ns/10ps
module aoc_block_ctrl_chk #(
  parameter int RST_DLY_CYC = 20
) (
  input wire logic       MCLK,
  input wire logic       SYS_RST,
  input wire logic       BLOCK_START_PERMIT_N,
  input wire logic       CUTTING_START_PERMIT_N,
  input wire logic       DRY_RUN_SELECT,
  input wire logic       RAPID_TRAVERSE_SELECT,
  input wire logic       MANUAL_OVERRIDE_VALID,
  input wire logic [4:0] MANUAL_FEEDRATE_CODE,
  input wire logic       RESET_AND_REWIND_REQUEST,
  input wire logic       FUNCTION_FINISH_FALLING,
  input wire logic       FUNCTION_FINISH_RISING,
  input wire logic       MANUAL_MODE,
  input wire logic [1:0] BLK_MOTION,
  input wire logic       BLOCK_START,
  input wire logic       SINGLE_STOPPED,
  input wire logic       FUNC_STROBE,
  input wire logic       AXIS_STOP,
  input wire logic [1:0] FEED_SOURCE,
  input wire logic [4:0] FEED_CODE,
  input wire logic       CUT_OVR_EN,
  input wire logic       RAPID_OVR_EN,
  input wire logic       IN_RESET,
  input wire logic       IN_REWIND,
  input wire logic       MODAL_INIT,
  input wire logic       OFFSET_CANCEL,
  input wire logic       ALARM_CLEAR,
  input wire logic       MCODE_OUT_CLEAR,
  input wire logic       MANUAL_INHIBIT
);
  int rwd_cnt_r;

  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  // Age of the rewind, so the delayed in-reset can be placed in a window
  always_ff @(posedge MCLK) begin
    if (SYS_RST || !IN_REWIND) begin
      rwd_cnt_r <= 0;
    end else begin
      rwd_cnt_r <= rwd_cnt_r + 1;
    end
  end

  property p_block_permit;
    BLOCK_START |-> !$past(BLOCK_START_PERMIT_N, 2);
  endproperty
  a_block_permit: assert property (p_block_permit)
    else $error("block started while block permit off");
  property p_cut_permit;
    BLOCK_START && BLK_MOTION == 2'h2 |-> !$past(CUTTING_START_PERMIT_N, 2);
  endproperty
  a_cut_permit: assert property (p_cut_permit)
    else $error("cutting block started while cutting permit off");
  property p_halt_quiet;
    SINGLE_STOPPED |-> !BLOCK_START;
  endproperty
  a_halt_quiet: assert property (p_halt_quiet)
    else $error("block started while halted");
  property p_dry_max;
    (DRY_RUN_SELECT && RAPID_TRAVERSE_SELECT && BLK_MOTION == 2'h2 && !MANUAL_MODE)[*3]
      |-> FEED_SOURCE == 2'h1 && !CUT_OVR_EN && !RAPID_OVR_EN;
  endproperty
  a_dry_max: assert property (p_dry_max)
    else $error("dry run with rapid select not at max cut feed");
  property p_dry_manual;
    (DRY_RUN_SELECT && !RAPID_TRAVERSE_SELECT && BLK_MOTION == 2'h2 && !MANUAL_MODE)[*3]
      |-> FEED_SOURCE == 2'h2 && CUT_OVR_EN == $past(MANUAL_OVERRIDE_VALID, 2)
          && FEED_CODE == $past(MANUAL_FEEDRATE_CODE, 2);
  endproperty
  a_dry_manual: assert property (p_dry_manual)
    else $error("dry run without rapid select not at manual feed");
  property p_dry_hand;
    (DRY_RUN_SELECT && MANUAL_MODE)[*3] |-> FEED_SOURCE != 2'h1 && FEED_SOURCE != 2'h2;
  endproperty
  a_dry_hand: assert property (p_dry_hand)
    else $error("dry run applied in manual operation");
  property p_rewind_hold;
    RESET_AND_REWIND_REQUEST[*3] |-> MANUAL_INHIBIT && !BLOCK_START;
  endproperty
  a_rewind_hold: assert property (p_rewind_hold)
    else $error("operation allowed while rewind held");
  property p_rewind_pulses;
    $rose(IN_REWIND) |-> MODAL_INIT && OFFSET_CANCEL && ALARM_CLEAR && MCODE_OUT_CLEAR;
  endproperty
  a_rewind_pulses: assert property (p_rewind_pulses)
    else $error("rewind reset actions missing");
  property p_rewind_delay;
    $rose(IN_RESET) && IN_REWIND |-> rwd_cnt_r >= RST_DLY_CYC - 3 && rwd_cnt_r <= RST_DLY_CYC + 3;
  endproperty
  a_rewind_delay: assert property (p_rewind_delay)
    else $error("in-reset after rewind outside its delay");
  property p_reset_pulses;
    $rose(IN_RESET) && !IN_REWIND |=> AXIS_STOP && ALARM_CLEAR && MCODE_OUT_CLEAR
                                      && OFFSET_CANCEL == MODAL_INIT;
  endproperty
  a_reset_pulses: assert property (p_reset_pulses)
    else $error("soft or modal reset actions missing");
  property p_finish_drop;
    FUNC_STROBE && (FUNCTION_FINISH_FALLING || FUNCTION_FINISH_RISING) |-> ##2 !FUNC_STROBE;
  endproperty
  a_finish_drop: assert property (p_finish_drop)
    else $error("strobe kept after finish");
  property p_finish_adv;
    BLOCK_START |-> !$past(FUNCTION_FINISH_FALLING, 2) && !$past(FUNCTION_FINISH_RISING, 2);
  endproperty
  a_finish_adv: assert property (p_finish_adv)
    else $error("next block before finish released");

  c_halt: cover property ($rose(SINGLE_STOPPED));
  c_finish: cover property ($fell(FUNC_STROBE));
  c_rewind: cover property ($rose(IN_RESET) && IN_REWIND);
endmodule

bind aoc_block_ctrl aoc_block_ctrl_chk #(.RST_DLY_CYC(RST_DLY_CYC)) u_chk (.*);

// *** bench/aoc_plc_model.sv ***
// Machine-side sequence controller answering function strobes with a finish.
// Assumes one clock; use_rising picks the finish line, slow delays the answer.
`timescale 1ns/10ps
module aoc_plc_model (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic use_rising,
  input  wire logic slow,
  input  wire logic func_strobe,
  output logic      finish_falling,
  output logic      finish_rising
);
  logic [2:0] wait_r;
  logic       fin_r;

  // Finish only follows a strobe, never a rewind, and drops once it is gone
  always_ff @(posedge mclk) begin
    if (sys_rst || !func_strobe) begin
      fin_r  <= 1'b0;
      wait_r <= slow ? 3'h5 : 3'h0;
    end else if (wait_r != 3'h0) begin
      wait_r <= wait_r - 3'h1;
    end else begin
      fin_r <= 1'b1;
    end
  end
  assign finish_falling = fin_r & ~use_rising;
  assign finish_rising  = fin_r & use_rising;
endmodule

// *** bench/tb_aoc_block_ctrl.sv ***
// Self-checking bench for the automatic block control.
// Assumes a 20 MHz clock; the bench also plays the execution core.
`timescale 1ns/10ps
module tb_aoc_block_ctrl;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [3:0] sel;
    logic [1:0] mot;
    logic [4:0] code;
    logic [2:0] exp;
  } aoc_row_type;
  logic MCLK, SYS_RST, REG_WR, REG_RD, SINGLE_STEP_REQUEST, CYCLE_START_REQUEST;
  logic BLOCK_START_PERMIT_N, CUTTING_START_PERMIT_N, DRY_RUN_SELECT, RAPID_TRAVERSE_SELECT;
  logic MANUAL_OVERRIDE_VALID, INPOSITION_CHECK_REQUEST, SOFT_RESET_REQUEST, MANUAL_MODE;
  logic MODAL_INIT_RESET_REQUEST, RESET_AND_REWIND_REQUEST, FUNCTION_FINISH_FALLING;
  logic FUNCTION_FINISH_RISING, MEMORY_MODE, BLK_VALID, BLK_STOP_OK, BLK_EXACT_STOP, BLK_MST;
  logic BLOCK_START, AUTO_ACTIVE, SINGLE_STOPPED, FUNC_STROBE, CUT_OVR_EN, RAPID_OVR_EN;
  logic AXIS_DECEL, AXIS_STOP, IN_RESET, IN_REWIND, MODAL_INIT, OFFSET_CANCEL, MEM_INDEX;
  logic ALARM_CLEAR, MCODE_OUT_CLEAR, MANUAL_INHIBIT, IN_POSITION, use_rising, slow;
  logic       MOTION_DONE = 1'b0;
  logic       AXES_STOPPED = 1'b0;
  logic [2:0] dly = 3'h0;
  logic [3:0] REG_ADDR;
  logic [7:0] REG_WDATA, REG_RDATA, d;
  logic [4:0] MANUAL_FEEDRATE_CODE, FEED_CODE;
  logic [1:0] BLK_MOTION, FEED_SOURCE;
  int err_count = 0, tests_run = 0, blk_cnt = 0, n_mi = 0, n_ix = 0, i, k, m, x;
  aoc_row_type rows [8] = '{
    '{8'h00, 4'b1100, 2'h2, 5'h05, 3'b010}, '{8'h00, 4'b1010, 2'h2, 5'h0a, 3'b101},
    '{8'h00, 4'b1000, 2'h2, 5'h1f, 3'b100}, '{8'h00, 4'b1011, 2'h2, 5'h03, 3'b001},
    '{8'h00, 4'b0000, 2'h2, 5'h11, 3'b001}, '{8'h00, 4'b1000, 2'h1, 5'h02, 3'b110},
    '{8'h01, 4'b1000, 2'h1, 5'h04, 3'b100}, '{8'h01, 4'b1100, 2'h1, 5'h06, 3'b110}};

  aoc_block_ctrl #(.RST_DLY_CYC(20)) uut (.*);
  aoc_plc_model plc (.mclk(MCLK), .sys_rst(SYS_RST), .use_rising(use_rising), .slow(slow),
    .func_strobe(FUNC_STROBE), .finish_falling(FUNCTION_FINISH_FALLING),
    .finish_rising(FUNCTION_FINISH_RISING));

  initial begin
    MCLK = 1'b0;
    forever #25 MCLK = ~MCLK;
  end

  // Execution core: motion ends four cycles after a block starts
  always @(posedge MCLK) begin
    if (BLOCK_START) blk_cnt <= blk_cnt + 1;
    dly <= BLOCK_START ? 3'h3 : (dly != 3'h0 ? dly - 3'h1 : 3'h0);
    MOTION_DONE <= (dly == 3'h1);
    AXES_STOPPED <= AXIS_DECEL;
    if (MODAL_INIT) n_mi <= n_mi + 1;
    if (MEM_INDEX) n_ix <= n_ix + 1;
  end

  task complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask
  // Settle one ns past the edge so sampled outputs have landed
  task tick(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask
  task wreg(input logic [3:0] a, input logic [7:0] v);
    @(posedge MCLK);
    REG_ADDR <= a;
    REG_WDATA <= v;
    REG_WR <= 1'b1;
    @(posedge MCLK);
    REG_WR <= 1'b0;
  endtask
  task rreg(input logic [3:0] a, output logic [7:0] v);
    @(posedge MCLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge MCLK);
    REG_RD <= 1'b0;
    #1 v = REG_RDATA;
  endtask
  task start;
    @(posedge MCLK);
    CYCLE_START_REQUEST <= 1'b1;
    tick(3);
    CYCLE_START_REQUEST <= 1'b0;
  endtask
  task wblk(input int n);
    for (int j = 0; j < 400 && blk_cnt < n; j++) tick(1);
    if (blk_cnt < n) begin
      $display("wrong value at %0t: got %h expected %h", $time, blk_cnt, n);
      err_count++;
      complete_run;
    end
  endtask
  task moving;
    wblk(blk_cnt + 2);
  endtask
  task stalled;
    int n;
    tick(10);
    n = blk_cnt;
    tick(30);
    chk(8'(blk_cnt - n), 8'h00);
  endtask

  initial begin
    {REG_WR, REG_RD, REG_ADDR, REG_WDATA, SINGLE_STEP_REQUEST, CYCLE_START_REQUEST,
     BLOCK_START_PERMIT_N, CUTTING_START_PERMIT_N, DRY_RUN_SELECT, RAPID_TRAVERSE_SELECT,
     MANUAL_OVERRIDE_VALID, MANUAL_FEEDRATE_CODE, INPOSITION_CHECK_REQUEST, SOFT_RESET_REQUEST,
     MODAL_INIT_RESET_REQUEST, RESET_AND_REWIND_REQUEST, MANUAL_MODE, BLK_VALID,
     BLK_EXACT_STOP, BLK_MST, use_rising, slow} <= '0;
    {SYS_RST, MEMORY_MODE, BLK_STOP_OK, IN_POSITION} <= 4'hf;
    BLK_MOTION <= 2'h1;
    tick(4);
    SYS_RST <= 1'b0;
    tick(1);
    chk({4'h0, BLOCK_START, AUTO_ACTIVE, IN_RESET, IN_REWIND}, 8'h00);
    rreg(aoc_pkg::CTRL_OFS, d);
    chk(d, aoc_pkg::CTRL_RST);
    wreg(aoc_pkg::STAT_OFS, 8'hff);
    rreg(aoc_pkg::STAT_OFS, d);
    chk(d, 8'h00);
    rreg(4'h8, d);
    chk(d, 8'h00);
    $display("reset and register test done");
    for (i = 0; i < 8; i++) begin
      {DRY_RUN_SELECT, RAPID_TRAVERSE_SELECT, MANUAL_OVERRIDE_VALID, MANUAL_MODE} <= rows[i].sel;
      BLK_MOTION <= rows[i].mot;
      MANUAL_FEEDRATE_CODE <= rows[i].code;
      wreg(aoc_pkg::CTRL_OFS, rows[i].ctrl);
      tick(4);
      chk({5'h00, FEED_SOURCE, CUT_OVR_EN}, {5'h00, rows[i].exp});
      chk({3'h0, FEED_CODE}, {3'h0, rows[i].code});
      chk({7'h00, RAPID_OVR_EN}, {7'h00, rows[i].exp[2:1] == 2'h3});
    end
    rreg(aoc_pkg::CTRL_OFS, d);
    chk(d, 8'h01);
    {DRY_RUN_SELECT, RAPID_TRAVERSE_SELECT, MANUAL_OVERRIDE_VALID, MANUAL_MODE} <= 4'h0;
    wreg(aoc_pkg::CTRL_OFS, 8'h00);
    $display("feed table test done");
    BLK_VALID <= 1'b1;
    SINGLE_STEP_REQUEST <= 1'b1;
    tick(10);
    chk(blk_cnt[7:0], 8'h00);
    start();
    wblk(1);
    tick(20);
    chk(blk_cnt[7:0], 8'h01);
    chk({7'h00, SINGLE_STOPPED}, 8'h01);
    start();
    wblk(2);
    tick(20);
    chk(blk_cnt[7:0], 8'h02);
    BLK_STOP_OK <= 1'b0;
    start();
    tick(60);
    chk({6'h00, SINGLE_STOPPED, blk_cnt > 4}, 8'h01);
    BLK_STOP_OK <= 1'b1;
    tick(20);
    chk({7'h00, SINGLE_STOPPED}, 8'h01);
    SINGLE_STEP_REQUEST <= 1'b0;
    start();
    moving();
    $display("single step test done");
    BLOCK_START_PERMIT_N <= 1'b1;
    stalled();
    chk({7'h00, AUTO_ACTIVE}, 8'h01);
    BLOCK_START_PERMIT_N <= 1'b0;
    moving();
    BLK_MOTION <= 2'h2;
    CUTTING_START_PERMIT_N <= 1'b1;
    stalled();
    BLK_MOTION <= 2'h1;
    moving();
    BLK_MOTION <= 2'h2;
    CUTTING_START_PERMIT_N <= 1'b0;
    IN_POSITION <= 1'b0;
    moving();
    INPOSITION_CHECK_REQUEST <= 1'b1;
    stalled();
    {INPOSITION_CHECK_REQUEST, BLK_EXACT_STOP, IN_POSITION} <= 3'b011;
    moving();
    IN_POSITION <= 1'b0;
    stalled();
    IN_POSITION <= 1'b1;
    moving();
    BLK_EXACT_STOP <= 1'b0;
    $display("interlock test done");
    BLK_MST <= 1'b1;
    for (i = 0; i < 4; i++) begin
      use_rising <= i[0];
      slow <= i[1];
      moving();
    end
    BLK_MST <= 1'b0;
    $display("function finish test done");
    x = n_ix;
    m = n_mi;
    RESET_AND_REWIND_REQUEST <= 1'b1;
    for (k = 0; k < 100 && IN_REWIND !== 1'b1; k++) tick(1);
    chk({6'h00, IN_REWIND, IN_RESET}, 8'h02);
    tick(2);
    chk({4'h0, 2'(n_mi - m), 2'(n_ix - x)}, 8'h05);
    tick(22);
    chk({6'h00, IN_RESET, MANUAL_INHIBIT}, 8'h03);
    m = blk_cnt;
    start();
    tick(10);
    chk(8'(blk_cnt - m), 8'h00);
    RESET_AND_REWIND_REQUEST <= 1'b0;
    tick(4);
    chk({6'h00, IN_REWIND, AUTO_ACTIVE}, 8'h00);
    $display("rewind test done");
    for (i = 0; i < 2; i++) begin
      x = n_ix;
      m = n_mi;
      {MODAL_INIT_RESET_REQUEST, SOFT_RESET_REQUEST} <= i[0] ? 2'b10 : 2'b01;
      tick(3);
      chk({7'h00, IN_RESET}, 8'h01);
      {MODAL_INIT_RESET_REQUEST, SOFT_RESET_REQUEST} <= 2'b00;
      tick(3);
      chk({6'h00, 1'(n_mi - m), 1'(n_ix - x)}, {6'h00, i[0], ~i[0]});
    end
    $display("soft and modal reset test done");
    complete_run;
  end
endmodule
